// >>> hw/asc_defs.svh
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ASC_OFF_CTRL 8'h00
`define ASC_OFF_STATUS 8'h04
`define ASC_OFF_RESULT 8'h08
`define ASC_OFF_IRQ_STAT 8'h0c
`define ASC_OFF_IRQ_MASK 8'h10
`define ASC_OFF_COUNT 8'h14
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASC_CTRL_START 0
`define ASC_ST_BUSY 0
`define ASC_ST_NAP 1
`define ASC_ST_CHAIN 2
`define ASC_ST_OE 3
`define ASC_ST_BITS_LSB 4
`define ASC_IRQ_DONE 0
`define ASC_IRQ_OVR 1
`define ASC_IRQ_RDOUT 2
`define ASC_IRQ_SCKBUSY 3
// ----------------------------------------
// Reset values and coding
// ----------------------------------------
`define ASC_RST_NAP 1'b1
`define ASC_RES_BITS 5'h10
`define ASC_SIGN_FLIP 16'h8000
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define ASC_SETTLE_CYC 2'h3
`endif

// >>> hw/asc_pkg.sv
package asc_pkg;
	typedef enum logic {
		asc_sar_idle = 1'b0,
		asc_sar_conv = 1'b1
	} asc_sar_st_type;

	typedef struct packed {
		logic trigger;
		logic chain_sel;
		logic rd_chain;
		logic sck;
		logic comp;
	} asc_pins_type;

	typedef struct packed {
		asc_pins_type meta;
		asc_pins_type stable;
	} asc_sync_state_type;

	typedef struct packed {
		asc_sar_st_type st;
		logic [15:0] code;
		logic [15:0] bit_sel;
		logic [1:0] wait_cnt;
		logic done;
		logic [15:0] result;
	} asc_sar_state_type;

	typedef struct packed {
		logic trig_q;
		logic sck_q;
		logic busy;
		logic nap;
		logic sw_start;
		logic [15:0] shift;
		logic [4:0] bits;
		logic sdo;
		logic sdo_oe;
		logic [15:0] result;
		logic [15:0] count;
		logic ack;
		logic [31:0] dat;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic irq;
	} asc_top_state_type;
endpackage

// >>> hw/asc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asc_sync (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pins in, stable copies out
	input wire asc_pkg::asc_pins_type d_i,
	output asc_pkg::asc_pins_type q_o
);
	import asc_pkg::*;
	asc_sync_state_type s_q;
	asc_sync_state_type s_d;

	// Meta stage feeds only the stable stage
	always_comb begin
		s_d = s_q;
		s_d.meta = d_i;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q_o = s_q.stable;
endmodule
`default_nettype wire

// >>> hw/asc_sar.sv
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.svh"
module asc_sar (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic start_i,
	input wire logic comp_i,
	output logic done_o,
	output logic [15:0] dac_o,
	output logic [15:0] result_o
);
	import asc_pkg::*;
	asc_sar_state_type s_q;
	asc_sar_state_type s_d;
	logic [15:0] kept;

	// ----------------------------------------
	// Bit trials
	// ----------------------------------------
	// Settle covers dac update plus comparator synchroniser
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		kept = comp_i ? s_q.code : (s_q.code & ~s_q.bit_sel);
		unique case (s_q.st)
			asc_sar_idle: begin
				if (start_i) begin
					s_d.st = asc_sar_conv;
					s_d.bit_sel = `ASC_SIGN_FLIP;
					s_d.code = `ASC_SIGN_FLIP;
					s_d.wait_cnt = `ASC_SETTLE_CYC;
				end
			end
			asc_sar_conv: begin
				if (s_q.wait_cnt != 2'h0) begin
					s_d.wait_cnt = s_q.wait_cnt - 2'h1;
				end else if (s_q.bit_sel[0]) begin
					s_d.st = asc_sar_idle;
					s_d.code = kept;
					s_d.result = kept ^ `ASC_SIGN_FLIP;
					s_d.done = 1'b1;
				end else begin
					s_d.bit_sel = s_q.bit_sel >> 1;
					s_d.code = kept | (s_q.bit_sel >> 1);
					s_d.wait_cnt = `ASC_SETTLE_CYC;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done_o = s_q.done;
	assign dac_o = s_q.code;
	assign result_o = s_q.result;

	AST_SAR_ONEHOT: assert property (@(posedge clk_i) disable iff (rst_i)
		s_q.st == asc_sar_conv |-> $onehot(s_q.bit_sel))
		else $error("trial bit not one-hot");
endmodule
`default_nettype wire

// >>> hw/asc_adc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.svh"

// Functional notes
// - Rising convert trigger ends acquisition and starts a new conversion.
// - Chain select low: normal mode, shared pin gates the serial output.
// - Chain select high: chain mode, shared pin is upstream serial input.
// - Busy rises as conversion starts, falls when it completes.
// - Enabled output shifts result MSB first, one bit per rising serial clock.
// - Result is a signed two's-complement word across the bipolar range.
// - End of conversion forms a 16-bit word ready for serial transfer.
// - Successive approximation tests weights from one half to 1/65536.
// - Internal timing paces conversion; host gives only the start edge.
// - Device naps automatically after each conversion.
// - Result readable right after its own conversion, no pipeline delay.
// - Normal mode drives output while read enable low, releases when high.
module asc_adc_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Converter pins
	input wire logic convert_trigger_i,
	input wire logic chain_sel_i,
	input wire logic read_enable_or_chain_in_i,
	input wire logic sck_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	output logic busy_o,
	output logic nap_o,
	// Analog core
	input wire logic comparator_i,
	output logic [15:0] sampling_cap_dac_o,
	// Interrupt
	output logic irq_o
);
	import asc_pkg::*;

	asc_top_state_type s_q;
	asc_top_state_type s_d;
	asc_pins_type pins_raw;
	asc_pins_type syn;
	logic trig_rise;
	logic sck_rise;
	logic start_req;
	logic start_acc;
	logic sar_done;
	logic [15:0] sar_result;
	logic bus_req;
	logic wr_en;
	logic shift_in;
	logic rd_last;
	logic [3:0] evt;
	logic [31:0] rd_mux;

	// ----------------------------------------
	// Pin synchronisers and conversion engine
	// ----------------------------------------
	assign pins_raw = '{
		trigger: convert_trigger_i,
		chain_sel: chain_sel_i,
		rd_chain: read_enable_or_chain_in_i,
		sck: sck_i,
		comp: comparator_i
	};

	asc_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(pins_raw),
		.q_o(syn)
	);

	asc_sar u_sar (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(start_acc),
		.comp_i(syn.comp),
		.done_o(sar_done),
		.dac_o(sampling_cap_dac_o),
		.result_o(sar_result)
	);

	// ----------------------------------------
	// Edges and events
	// ----------------------------------------
	assign trig_rise = syn.trigger & ~s_q.trig_q;
	assign sck_rise = syn.sck & ~s_q.sck_q;
	assign start_req = trig_rise | s_q.sw_start;
	// A start during conversion is dropped and flagged
	assign start_acc = start_req & ~s_q.busy;
	assign shift_in = syn.chain_sel & syn.rd_chain;
	assign rd_last = sck_rise & ~sar_done & (s_q.bits == 5'h01);
	assign evt[`ASC_IRQ_DONE] = sar_done;
	assign evt[`ASC_IRQ_OVR] = start_req & s_q.busy;
	assign evt[`ASC_IRQ_RDOUT] = rd_last;
	// Clocking during conversion shifts stale data
	assign evt[`ASC_IRQ_SCKBUSY] = sck_rise & s_q.busy;

	// ----------------------------------------
	// Wishbone decode
	// ----------------------------------------
	assign bus_req = wb_cyc_i & wb_stb_i;
	// Write lands on the edge where the master sees ack
	assign wr_en = bus_req & wb_we_i & s_q.ack & wb_sel_i[0];

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (wb_adr_i)
			`ASC_OFF_STATUS: begin
				rd_mux[`ASC_ST_BUSY] = s_q.busy;
				rd_mux[`ASC_ST_NAP] = s_q.nap;
				rd_mux[`ASC_ST_CHAIN] = syn.chain_sel;
				rd_mux[`ASC_ST_OE] = s_q.sdo_oe;
				rd_mux[`ASC_ST_BITS_LSB +: 5] = s_q.bits;
			end
			`ASC_OFF_RESULT: begin
				rd_mux[15:0] = s_q.result;
			end
			`ASC_OFF_IRQ_STAT: begin
				rd_mux[3:0] = s_q.irq_stat;
			end
			`ASC_OFF_IRQ_MASK: begin
				rd_mux[3:0] = s_q.irq_mask;
			end
			`ASC_OFF_COUNT: begin
				rd_mux[15:0] = s_q.count;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.trig_q = syn.trigger;
		s_d.sck_q = syn.sck;
		s_d.sw_start = 1'b0;

		// Conversion flags
		if (start_acc) begin
			s_d.busy = 1'b1;
			s_d.nap = 1'b0;
		end
		if (sar_done) begin
			s_d.busy = 1'b0;
			s_d.nap = 1'b1;
			s_d.result = sar_result;
			s_d.count = s_q.count + 16'h0001;
		end

		// Output shifter; a fresh result wins over a shift
		if (sar_done) begin
			s_d.shift = sar_result;
			s_d.bits = `ASC_RES_BITS;
		end else if (sck_rise) begin
			s_d.shift = {s_q.shift[14:0], shift_in};
			if (s_q.bits != 5'h00) begin
				s_d.bits = s_q.bits - 5'h01;
			end
		end
		s_d.sdo = s_d.shift[15];

		// Output enable
		if (syn.chain_sel) begin
			s_d.sdo_oe = 1'b1;
		end else begin
			s_d.sdo_oe = ~syn.rd_chain;
		end

		// Bus answer, one cycle ack then drop
		s_d.ack = bus_req & ~s_q.ack;
		s_d.dat = s_d.ack ? rd_mux : 32'h0000_0000;

		// Register writes
		if (wr_en) begin
			unique case (wb_adr_i)
				`ASC_OFF_CTRL: begin
					s_d.sw_start = wb_dat_i[`ASC_CTRL_START];
				end
				`ASC_OFF_IRQ_STAT: begin
					s_d.irq_stat = s_q.irq_stat & ~wb_dat_i[3:0];
				end
				`ASC_OFF_IRQ_MASK: begin
					s_d.irq_mask = wb_dat_i[3:0];
				end
				default: begin
					s_d.irq_mask = s_q.irq_mask;
				end
			endcase
		end

		// New events beat a clear in the same cycle
		s_d.irq_stat = s_d.irq_stat | evt;
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.nap <= `ASC_RST_NAP;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = s_q.dat;
	assign sdo_o = s_q.sdo;
	assign sdo_oe_o = s_q.sdo_oe;
	assign busy_o = s_q.busy;
	assign nap_o = s_q.nap;
	assign irq_o = s_q.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence seq_conv_start;
		start_acc;
	endsequence

	sequence seq_conv_end;
		sar_done ##1 (!busy_o && nap_o && s_q.bits == `ASC_RES_BITS);
	endsequence

	AST_CONV_TIME: assert property (seq_conv_start |-> ##65 seq_conv_end)
		else $error("conversion did not end on time");

	AST_BUSY_RISE: assert property (seq_conv_start |=> busy_o && !nap_o)
		else $error("busy did not rise on start");

	AST_DAC_FIRST: assert property (seq_conv_start |=>
		sampling_cap_dac_o == `ASC_SIGN_FLIP)
		else $error("first trial not half scale");

	AST_BUSY_HOLD: assert property (busy_o && !sar_done |=> busy_o)
		else $error("busy fell before completion");

	AST_NO_NAP_BUSY: assert property (busy_o |-> !nap_o)
		else $error("napping during conversion");

	AST_TWOS: assert property (sar_done |->
		sar_result == (sampling_cap_dac_o ^ `ASC_SIGN_FLIP))
		else $error("result not two's complement");

	AST_LOAD: assert property (sar_done |=>
		sdo_o == $past(sar_result[15]) && s_q.result == $past(sar_result))
		else $error("result not presented");

	AST_SHIFT: assert property (sck_rise && !sar_done |=>
		s_q.shift == {$past(s_q.shift[14:0]), $past(shift_in)} && sdo_o == s_q.shift[15])
		else $error("shift step wrong");

	AST_CHAIN_FWD: assert property (sck_rise && !sar_done && syn.chain_sel |=>
		s_q.shift[0] == $past(syn.rd_chain))
		else $error("chain bit not forwarded");

	AST_OE_NORMAL: assert property (!syn.chain_sel |=>
		sdo_oe_o == !$past(syn.rd_chain))
		else $error("normal mode enable wrong");

	AST_OE_CHAIN: assert property (syn.chain_sel |=> sdo_oe_o)
		else $error("chain mode output not driven");

	AST_OVR_IGNORED: assert property (start_req && busy_o && !sar_done |=>
		busy_o && s_q.irq_stat[`ASC_IRQ_OVR])
		else $error("overrun not flagged");

	AST_IRQ: assert property (irq_o == |(s_q.irq_stat & s_q.irq_mask))
		else $error("interrupt level wrong");

	AST_ACK: assert property (bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not single cycle");

	AST_ACK_NEEDS_REQ: assert property (wb_ack_o |-> $past(bus_req))
		else $error("ack without a request");

	// Event flags and register side effects
	AST_DONE_FLAG: assert property (sar_done |=> s_q.irq_stat[`ASC_IRQ_DONE])
		else $error("done event not flagged");

	AST_RDOUT_FLAG: assert property (rd_last |=> s_q.irq_stat[`ASC_IRQ_RDOUT])
		else $error("readout event not flagged");

	AST_SCK_BUSY_FLAG: assert property (sck_rise && busy_o |=>
		s_q.irq_stat[`ASC_IRQ_SCKBUSY])
		else $error("clock during conversion not flagged");

	AST_BUSY_ONLY_START: assert property (!busy_o && !start_acc |=> !busy_o)
		else $error("busy rose without a start");

	AST_NAP_HOLD: assert property (nap_o && !start_acc |=> nap_o)
		else $error("left nap without a start");

	AST_RESULT_HOLD: assert property (!sar_done |=> $stable(s_q.result))
		else $error("result changed without a conversion");

	AST_SDO_HOLD: assert property (!sck_rise && !sar_done |=> $stable(sdo_o))
		else $error("serial output moved without a clock");

	AST_BITS_COUNT: assert property (sck_rise && !sar_done && s_q.bits != 5'h00 |=>
		s_q.bits == $past(s_q.bits) - 5'h01)
		else $error("bit count step wrong");

	AST_COUNT_STEP: assert property (sar_done |=> s_q.count == $past(s_q.count) + 16'h0001)
		else $error("conversion count step wrong");

	AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");

	AST_MASK_WRITE: assert property (wr_en && wb_adr_i == `ASC_OFF_IRQ_MASK |=>
		s_q.irq_mask == $past(wb_dat_i[3:0]))
		else $error("mask write lost");

	AST_W1C: assert property (wr_en && wb_adr_i == `ASC_OFF_IRQ_STAT && wb_dat_i[0] && !evt[0]
		|=> !s_q.irq_stat[`ASC_IRQ_DONE])
		else $error("done flag not cleared");

	AST_SW_START: assert property (wr_en && wb_adr_i == `ASC_OFF_CTRL && wb_dat_i[0] && !busy_o
		|=> ##1 busy_o)
		else $error("software start ignored");
endmodule
`default_nettype wire

// >>> test/asc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
	// Clock
	input wire logic clk_i,
	// Device side
	input wire logic sdo_i,
	input wire logic sdo_oe_i,
	input wire logic [15:0] dac_i,
	output logic trig_o,
	output logic sck_o,
	output logic sdi_o,
	output logic comp_o
);
	// ----------------
	// Analog stand-in
	// ----------------
	logic [15:0] vin_q = 16'h0000;
	// Ideal comparator on an offset-binary level
	assign comp_o = (dac_i <= vin_q);
	// Released line reads as the inverse, so late enables show up
	logic sdo_line;
	assign sdo_line = sdo_oe_i ? sdo_i : ~sdo_i;
	initial begin
		trig_o = 1'b0;
		sck_o = 1'b0;
		sdi_o = 1'b1;
	end
	// ----------------
	// Host actions
	// ----------------
	// Clock stays low outside frames; trigger pulse holds it idle
	task automatic convert(input logic [15:0] vin);
		@(posedge clk_i);
		vin_q <= vin;
		trig_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		trig_o <= 1'b0;
	endtask
	task automatic set_rd(input logic v);
		@(posedge clk_i);
		sdi_o <= v;
	endtask
	// Shared pin carries s MSB first; 800 ns clock period
	task automatic shift(input int n, input logic [31:0] s, output logic [31:0] got);
		got = 32'h0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			sdi_o <= s[31-i];
			repeat (3) @(posedge clk_i);
			got = {got[30:0], sdo_line};
			sck_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			sck_o <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// >>> test/test_sar_adc_convert_and_serial_readout.sv
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_convert_and_serial_readout;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_wd = 32'h0;
	logic [31:0] wb_rd;
	logic wb_ack;
	logic chain_sel = 1'b0;
	logic trig, sck, sdi, comp, sdo, oe, busy, nap, irq;
	logic [15:0] dac, vin, cw;
	logic [31:0] rd, got;
	int num_errors = 0;
	int cmp_count = 0;
	always #50 clk_i = ~clk_i;
	asc_adc_ctrl uut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wd),
		.wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .convert_trigger_i(trig),
		.chain_sel_i(chain_sel), .read_enable_or_chain_in_i(sdi), .sck_i(sck),
		.sdo_o(sdo), .sdo_oe_o(oe), .busy_o(busy), .nap_o(nap),
		.comparator_i(comp), .sampling_cap_dac_o(dac), .irq_o(irq)
	);
	asc_host_model host (
		.clk_i(clk_i), .sdo_i(sdo), .sdo_oe_i(oe), .dac_i(dac), .trig_o(trig),
		.sck_o(sck), .sdi_o(sdi), .comp_o(comp)
	);
	// ----------------
	// Helpers
	// ----------------
	// Offset-binary level to signed word
	function automatic logic [15:0] exp_res(input logic [15:0] v);
		return v ^ 16'h8000;
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wd <= wd;
		// Only the watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (wb_ack !== 1'b1);
		rd = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask
	// Bounded wait for the end of a conversion
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ----------------
	// Sequence
	// ----------------
	initial begin
		void'($urandom(85569));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		check("nap", 1, nap);
		wb(0, 8'h04, 0);
		check("status", 32'h2, rd);
		wb(0, 8'h1c, 0);
		check("unmapped", 0, rd);
		wb(1, 8'h10, 32'h1);
		// Corners first, then random levels
		for (int k = 0; k < 6; k++) begin
			vin = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : (k == 2) ? 16'h8000 :
				(k == 3) ? 16'h7fff : 16'($urandom);
			host.convert(vin);
			check("busy_rise", 1, busy);
			wait_idle();
			check("busy_fall", 0, busy);
			check("nap_after", 1, nap);
			check("irq_set", 1, irq);
			wb(0, 8'h08, 0);
			check("result", exp_res(vin), rd);
			host.set_rd(1'b0);
			repeat (3) @(posedge clk_i);
			host.shift(16, 32'h0, got);
			check("sdo_word", exp_res(vin), got);
			check("oe_low_rd", 1, oe);
			host.set_rd(1'b1);
			repeat (4) @(posedge clk_i);
			check("oe_high_rd", 0, oe);
			wb(0, 8'h0c, 0);
			check("irq_stat", 32'h5, rd);
			wb(1, 8'h0c, 32'hf);
			repeat (2) @(posedge clk_i);
			check("irq_clr", 0, irq);
		end
		// Chain mode: own word, then upstream bits in order
		chain_sel <= 1'b1;
		vin = 16'($urandom);
		cw = 16'($urandom);
		host.convert(vin);
		wait_idle();
		host.shift(32, {cw, 16'h0}, got);
		check("chain", {exp_res(vin), cw}, got);
		check("oe_chain", 1, oe);
		// Software start, then a trigger while busy is refused
		wb(1, 8'h0c, 32'hf);
		wb(1, 8'h00, 32'h1);
		repeat (2) @(posedge clk_i);
		check("sw_busy", 1, busy);
		host.convert(16'h1234);
		wait_idle();
		wb(0, 8'h0c, 0);
		check("overrun", 32'h3, rd);
		wb(0, 8'h14, 0);
		check("count", 32'h8, rd);
		wb(1, 8'h10, 32'h0);
		repeat (2) @(posedge clk_i);
		check("irq_masked", 0, irq);
		wrap_up();
	end
	// Whole run is well under this span
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		wrap_up();
	end
endmodule
`default_nettype wire
